// *** verilog/mit_timer.v ***
// modulo interval timer: control register, tick select, 8-bit count and match
`timescale 1ns/100ps
`include "mit_regs.vh"
module mit_timer (
	input  wire       core_clk_i,
	input  wire       reset_i,
	input  wire       chip_en_reset_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	input  wire [7:0] reg_addr_i,
	input  wire [3:0] reg_wdata_i,
	output reg  [3:0] reg_rdata_o,
	input  wire       buf_put_i,
	input  wire       buf_get_i,
	input  wire [7:0] transfer_buffer_i,
	output reg  [7:0] transfer_buffer_o,
	output reg        irq_o,
	output wire [7:0] count_value_o,
	output wire [7:0] match_limit_o
);
	// stored control fields and the rate actually in use
	reg  [1:0] tick_sel_ff;
	reg        run_enable_ff;
	reg  [1:0] cur_sel_ff;

	// count path
	reg  [7:0] count_value_ff;
	reg  [7:0] match_limit_ff;
	reg        nxt_irq;
	reg  [7:0] nxt_count;
	wire [7:0] count_inc;
	wire       count_hit;
	wire       count_step;

	// divided basic ticks and the one picked by the select
	reg        sel_tick;
	wire       tick_100k;
	wire       tick_10k;
	wire       tick_2k;
	wire       tick_1k;

	// decoded register and buffer strokes
	wire       ctrl_wr;
	wire       ctrl_take;
	wire       ctrl_rd;
	wire       limit_wr;
	wire       count_rd;
	wire       clear_req;
	wire [1:0] wr_sel;
	wire       wr_run;
	wire [3:0] ctrl_view;

	// reset image of the control register; only the stored bits are used
	localparam [3:0] CTRL_RST = `MIT_CTRL_RESET;

	// address decode; each stroke is taken on the edge where it is high
	assign ctrl_wr       = reg_wr_i && (reg_addr_i == `MIT_CTRL_ADDR);
	assign ctrl_take     = ctrl_wr && !chip_en_reset_i;
	assign ctrl_rd       = reg_rd_i && (reg_addr_i == `MIT_CTRL_ADDR);
	assign limit_wr      = buf_put_i && (reg_addr_i == `MIT_LIMIT_ADDR) && !chip_en_reset_i;
	assign count_rd      = buf_get_i && (reg_addr_i == `MIT_COUNT_ADDR);
	assign clear_req     = ctrl_take && reg_wdata_i[`MIT_BIT_CLEAR];

	// write data split into the stored control fields
	assign wr_sel        = {reg_wdata_i[`MIT_BIT_SEL_HI], reg_wdata_i[`MIT_BIT_SEL_LO]};
	assign wr_run        = reg_wdata_i[`MIT_BIT_RUN];

	// read image of control; the clear position is never stored, so it reads 0
	assign ctrl_view     = {run_enable_ff, 1'b0, tick_sel_ff};

	// a step happens only on a selected tick while running; the match is judged
	// on the value the step would reach, so the limit value is never held
	assign count_step    = run_enable_ff && sel_tick;
	assign count_inc     = count_value_ff + 8'h01;
	assign count_hit     = (count_inc == match_limit_ff);

	// register images seen from outside
	assign count_value_o = count_value_ff;
	assign match_limit_o = match_limit_ff;

	// one shared divider per basic rate; the timer only picks among them
	// 10 us basic period
	mit_tick_div #(.DIV(`MIT_DIV_100K)) u_div_100k (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.tick_o     (tick_100k)
	);
	// 100 us basic period
	mit_tick_div #(.DIV(`MIT_DIV_10K)) u_div_10k (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.tick_o     (tick_10k)
	);
	// 500 us basic period
	mit_tick_div #(.DIV(`MIT_DIV_2K)) u_div_2k (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.tick_o     (tick_2k)
	);
	// 1 ms basic period
	mit_tick_div #(.DIV(`MIT_DIV_1K)) u_div_1k (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.tick_o     (tick_1k)
	);

	// tick mux; while running, the select is resampled only on a tick of the old rate,
	// so a change waits for a boundary instead of cutting a period short
	always @* begin
		case (cur_sel_ff)
			`MIT_SEL_100K: sel_tick = tick_100k;
			`MIT_SEL_10K:  sel_tick = tick_10k;
			`MIT_SEL_2K:   sel_tick = tick_2k;
			`MIT_SEL_1K:   sel_tick = tick_1k;
			default:       sel_tick = 1'b0;
		endcase
	end

	// a select written while stopped is taken at once, so a start never counts
	// a tick of the old rate; while running it waits for a tick of the old rate
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			cur_sel_ff <= `MIT_SEL_100K;
		end else if (ctrl_take && !run_enable_ff) begin
			cur_sel_ff <= wr_sel;
		end else if (sel_tick || !run_enable_ff) begin
			cur_sel_ff <= tick_sel_ff;
		end
	end

	// control register; the clear bit is not stored and chip-enable reset keeps it
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			tick_sel_ff   <= CTRL_RST[`MIT_BIT_SEL_HI:`MIT_BIT_SEL_LO];
			run_enable_ff <= CTRL_RST[`MIT_BIT_RUN];
		end else if (ctrl_take) begin
			tick_sel_ff   <= wr_sel;
			run_enable_ff <= wr_run;
		end
	end

	// control read, registered so read data comes from a flip-flop; it is
	// valid from the edge that takes the read until the next edge, and any
	// other address or an idle cycle gives zero
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 4'h0;
		end else if (ctrl_rd) begin
			reg_rdata_o <= ctrl_view;
		end else begin
			reg_rdata_o <= 4'h0;
		end
	end

	// limit register written from the transfer buffer; kept on chip-enable reset.
	// a limit of zero must not be programmed: the count would then match only
	// when it rolls past all ones, giving a request every 256 ticks
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			match_limit_ff <= `MIT_LIMIT_RESET;
		end else if (limit_wr) begin
			match_limit_ff <= transfer_buffer_i;
		end
	end

	// count next state: clear write wins, match wraps, stop holds;
	// a clear in the same cycle as a matching tick swallows that request,
	// which is the start error the user must accept
	always @* begin
		nxt_count = count_value_ff;
		nxt_irq   = 1'b0;
		if (clear_req) begin
			nxt_count = `MIT_COUNT_RESET;
		end else if (count_step) begin
			if (count_hit) begin
				nxt_count = `MIT_COUNT_RESET;
				nxt_irq   = 1'b1;
			end else begin
				nxt_count = count_inc;
			end
		end
	end

	// the matching value is never held; wrapping on the tick that reaches
	// the limit gives exactly N ticks between requests
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			count_value_ff <= `MIT_COUNT_RESET;
			irq_o          <= 1'b0;
		end else begin
			count_value_ff <= nxt_count;
			irq_o          <= nxt_irq;
		end
	end

	// count read out into the transfer buffer; the captured value stands
	// until the next get, so software may read it at leisure while the
	// counter itself keeps running
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			transfer_buffer_o <= 8'h00;
		end else if (count_rd) begin
			transfer_buffer_o <= count_value_ff;
		end
	end
endmodule

// *** verilog/mit_regs.vh ***
// register offsets, field positions, reset values and tick timing of the modulo interval timer
`ifndef MIT_REGS_VH
`define MIT_REGS_VH

`define MIT_CTRL_ADDR        8'h29
`define MIT_COUNT_ADDR       8'h1F
`define MIT_LIMIT_ADDR       8'h1E
`define MIT_CTRL_RESET       4'h0
`define MIT_LIMIT_RESET      8'hFF
`define MIT_COUNT_RESET      8'h00
`define MIT_BIT_SEL_LO       0
`define MIT_BIT_SEL_HI       1
`define MIT_BIT_CLEAR        2
`define MIT_BIT_RUN          3
`define MIT_SEL_100K         2'h0
`define MIT_SEL_10K          2'h1
`define MIT_SEL_2K           2'h2
`define MIT_SEL_1K           2'h3
`define MIT_CLK_HZ           200000000
`define MIT_F100K_HZ         100000
`define MIT_F10K_HZ          10000
`define MIT_F2K_HZ           2000
`define MIT_F1K_HZ           1000
// core clock cycles per basic tick, clock rate over tick rate, sized for the divider
`define MIT_DIV_100K         18'h007D0
`define MIT_DIV_10K          18'h04E20
`define MIT_DIV_2K           18'h186A0
`define MIT_DIV_1K           18'h30D40

`endif

// *** verilog/mit_tick_div.v ***
// free-running divider that gives one-cycle tick pulses at a programmable period
`timescale 1ns/100ps
module mit_tick_div #(
	parameter [17:0] DIV = 18'h007D0
) (
	input  wire core_clk_i,
	input  wire reset_i,
	output wire tick_o
);
	reg [17:0] cnt_ff;
	wire [17:0] nxt_cnt;

	// wrap at DIV-1; tick on the last count of each period
	assign tick_o  = (cnt_ff == DIV - 18'h00001);
	assign nxt_cnt = tick_o ? 18'h00000 : cnt_ff + 18'h00001;

	always @(posedge core_clk_i) begin
		if (reset_i) begin
			cnt_ff <= 18'h00000;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// *** bench/mit_timer_props.sv ***
// port assertions for the modulo interval timer
`timescale 1ns/100ps
module mit_timer_props (
	input wire       core_clk_i,
	input wire       reset_i,
	input wire       chip_en_reset_i,
	input wire       reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [3:0] reg_rdata_o,
	input wire       buf_put_i,
	input wire       buf_get_i,
	input wire [7:0] transfer_buffer_i,
	input wire [7:0] transfer_buffer_o,
	input wire       irq_o,
	input wire [7:0] count_value_o,
	input wire [7:0] match_limit_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// the two buffer strokes, each taken on one edge
	sequence s_get; buf_get_i && reg_addr_i == 8'h1F; endsequence
	sequence s_put; buf_put_i && reg_addr_i == 8'h1E && !chip_en_reset_i; endsequence
	property p_get; s_get |=> transfer_buffer_o == $past(count_value_o); endproperty
	a_get: assert property (p_get) else $error("get data wrong");
	property p_put; s_put |=> match_limit_o == $past(transfer_buffer_i); endproperty
	a_put: assert property (p_put) else $error("limit not stored");
	property p_rd_clr; reg_rd_i && reg_addr_i == 8'h29 |=> !reg_rdata_o[2]; endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("clear bit read 1");
	property p_irq_zero; irq_o |-> count_value_o == 8'h00; endproperty
	a_irq_zero: assert property (p_irq_zero) else $error("no wrap at match");
	property p_irq_gap; irq_o |=> !irq_o [*8]; endproperty
	a_irq_gap: assert property (p_irq_gap) else $error("request too soon");
	// the count only steps up by one or returns to zero
	property p_step; !$stable(count_value_o) |->
		count_value_o == $past(count_value_o) + 8'h01 || count_value_o == 8'h00; endproperty
	a_step: assert property (p_step) else $error("count jumped");
	property p_reset; disable iff (1'b0) reset_i |=>
		count_value_o == 8'h00 && match_limit_o == 8'hFF && !irq_o; endproperty
	a_reset: assert property (p_reset) else $error("bad reset values");
	property p_cer; chip_en_reset_i |=> $stable(match_limit_o); endproperty
	a_cer: assert property (p_cer) else $error("limit lost");
endmodule
bind mit_timer mit_timer_props u_props (.*);

// *** bench/test_mit_timer.sv ***
// register-level bench for the modulo interval timer
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module test_mit_timer;
	reg        core_clk_i = 0, reset_i = 1, chip_en_reset_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	reg        buf_put_i = 0, buf_get_i = 0;
	reg  [7:0] reg_addr_i = 8'h00, transfer_buffer_i = 8'h00;
	reg  [3:0] reg_wdata_i = 4'h0;
	wire [3:0] reg_rdata_o;
	wire [7:0] transfer_buffer_o, count_value_o, match_limit_o;
	wire       irq_o;
	integer    err_count = 0, checked = 0, cyc = 0, n, s;
	mit_timer u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.chip_en_reset_i(chip_en_reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.buf_put_i(buf_put_i), .buf_get_i(buf_get_i), .transfer_buffer_i(transfer_buffer_i),
		.transfer_buffer_o(transfer_buffer_o), .irq_o(irq_o),
		.count_value_o(count_value_o), .match_limit_o(match_limit_o));
	always #2.5 core_clk_i = ~core_clk_i;
	task end_sim;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// hang guard: the longest path needs about 60000 cycles
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			end_sim;
		end
	end
	// inputs always move 1 ns after the rising edge
	task step; @(posedge core_clk_i) #1; endtask
	task wr(input [3:0] d);
		reg_addr_i = 8'h29; reg_wdata_i = d; reg_wr_i = 1; step; reg_wr_i = 0;
	endtask
	task rd(input [7:0] a, input [3:0] e);
		reg_addr_i = a; reg_rd_i = 1; step; `CHK(reg_rdata_o, e) reg_rd_i = 0; step;
	endtask
	task put(input [7:0] v);
		reg_addr_i = 8'h1E; transfer_buffer_i = v; buf_put_i = 1; step; buf_put_i = 0;
	endtask
	task get(input [7:0] e);
		reg_addr_i = 8'h1F; buf_get_i = 1; step; buf_get_i = 0; `CHK(transfer_buffer_o, e)
	endtask
	// cycles until a request, capped at lim
	task wirq(input integer lim, output integer c);
		c = 0;
		while (irq_o !== 1'b1 && c < lim) begin step; c++; end
		step;
	endtask
	initial begin
		repeat (16) step;
		reset_i = 0;
		rd(8'h29, 4'h0);
		rd(8'h2A, 4'h0);
		get(8'h00);
		`CHK(match_limit_o, 8'hFF)
		for (s = 0; s < 4; s++) begin wr(s); rd(8'h29, s); end
		wr(4'hF); rd(8'h29, 4'hB);
		wr(4'h0); put(8'h03); `CHK(match_limit_o, 8'h03)
		wr(4'h8); wirq(9000, n); wirq(9000, n); `CHK(n + 1, 6000)
		`CHK(count_value_o, 8'h00)
		repeat (2005) step; get(8'h01);
		wr(4'hC); `CHK(count_value_o, 8'h00)
		rd(8'h29, 4'h8);
		wr(4'h0); wirq(7000, n); `CHK(n, 7000)
		`CHK(count_value_o, 8'h00)
		chip_en_reset_i = 1; put(8'h55); chip_en_reset_i = 0;
		`CHK(match_limit_o, 8'h03)
		step; put(8'h01); wr(4'h9); wirq(45000, n); wirq(45000, n); `CHK(n + 1, 20000)
		// a second reset in mid-run must bring back the power-on values
		reset_i = 1; repeat (2) step; reset_i = 0;
		`CHK(match_limit_o, 8'hFF)
		`CHK(count_value_o, 8'h00)
		rd(8'h29, 4'h0);
		end_sim;
	end
endmodule
